//--- rtl/srdm_supervisor.sv
`timescale 1ns/100ps
module srdm_supervisor
  import srdm_pkg::*;
#(
  parameter int HOLD_1P4_CYC = SRDM_HOLD_1P4_CYC,
  parameter int HOLD_30_CYC  = SRDM_HOLD_30_CYC,
  parameter int HOLD_200_CYC = SRDM_HOLD_200_CYC,
  parameter int HOLD_1P6_CYC = SRDM_HOLD_1P6_CYC,
  parameter int QUALIFY_CYC  = SRDM_QUALIFY_CYC
) (
  input  wire logic           mclk,
  input  wire logic           reset_n,
  input  wire logic           supply_ok,
  input  wire logic           manual_reset_n_input,
  input  wire logic           watchdog_expired,
  input  wire srdm_hold_sel_t hold_sel,
  output srdm_rst_out_t       rst_out
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [1:0] sup_sync_reg, sup_sync_next;
  logic [1:0] mr_sync_reg,  mr_sync_next;
  logic [1:0] wd_sync_reg,  wd_sync_next;

  // Two stages; only stage 1 is read by logic
  always_comb begin
    sup_sync_next = {sup_sync_reg[0], supply_ok};
    mr_sync_next  = {mr_sync_reg[0], manual_reset_n_input};
    wd_sync_next  = {wd_sync_reg[0], watchdog_expired};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sup_sync_reg <= 2'b00;
      mr_sync_reg  <= 2'b11;
      wd_sync_reg  <= 2'b00;
    end else begin
      sup_sync_reg <= sup_sync_next;
      mr_sync_reg  <= mr_sync_next;
      wd_sync_reg  <= wd_sync_next;
    end
  end

  wire logic sup_ok = sup_sync_reg[1];
  wire logic mr_low = ~mr_sync_reg[1];
  wire logic wd_exp = wd_sync_reg[1];

  // ==========================================================================
  // Manual reset qualify counter
  // ==========================================================================
  logic [SRDM_CNT_W-1:0] mr_cnt_reg, mr_cnt_next;
  logic                  mr_qual;

  // Low time must exceed the glitch window and reach the qualify time
  localparam int QUAL_CYC = (QUALIFY_CYC > SRDM_GLITCH_CYC) ? QUALIFY_CYC : SRDM_GLITCH_CYC + 1;

  always_comb begin
    mr_cnt_next = '0;
    if (mr_low) begin
      mr_cnt_next = (mr_cnt_reg == SRDM_CNT_W'(QUAL_CYC)) ? mr_cnt_reg : mr_cnt_reg + 1'b1;
    end
  end
  assign mr_qual = (mr_cnt_reg == SRDM_CNT_W'(QUAL_CYC));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mr_cnt_reg <= '0;
    end else begin
      mr_cnt_reg <= mr_cnt_next;
    end
  end

  // ==========================================================================
  // Hold delay selection
  // ==========================================================================
  function automatic logic [SRDM_CNT_W-1:0] hold_len(input srdm_hold_sel_t s);
    case (s)
      SRDM_HOLD_1P4MS: hold_len = SRDM_CNT_W'(HOLD_1P4_CYC);
      SRDM_HOLD_30MS:  hold_len = SRDM_CNT_W'(HOLD_30_CYC);
      SRDM_HOLD_1P6S:  hold_len = SRDM_CNT_W'(HOLD_1P6_CYC);
      default:         hold_len = SRDM_CNT_W'(HOLD_200_CYC);
    endcase
  endfunction

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  srdm_state_t           st_reg, st_next;
  logic [SRDM_CNT_W-1:0] hold_reg, hold_next;
  logic                  cause;

  // Any cause keeps reset asserted; power-up is the ASSERT reset state
  assign cause = ~sup_ok | mr_qual | wd_exp;

  always_comb begin
    st_next   = st_reg;
    hold_next = hold_reg;
    case (st_reg)
      SRDM_ST_ASSERT: begin
        hold_next = '0;
        if (!cause) begin
          st_next = SRDM_ST_HOLD;
        end
      end
      SRDM_ST_HOLD: begin
        if (cause) begin
          st_next   = SRDM_ST_ASSERT;
          hold_next = '0;
        end else if (hold_reg >= hold_len(hold_sel) - 1'b1) begin
          st_next   = SRDM_ST_RUN;
        end else begin
          hold_next = hold_reg + 1'b1;
        end
      end
      SRDM_ST_RUN: begin
        if (cause) begin
          st_next = SRDM_ST_ASSERT;
        end
      end
      default: begin
        st_next = SRDM_ST_ASSERT;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg   <= SRDM_ST_ASSERT;
      hold_reg <= '0;
    end else begin
      st_reg   <= st_next;
      hold_reg <= hold_next;
    end
  end

  // ==========================================================================
  // Output register; a drop of supply_ok asserts on the third edge, after the two sync stages
  // ==========================================================================
  srdm_rst_out_t out_reg, out_next;

  always_comb begin
    out_next.rst_n = (st_next == SRDM_ST_RUN);
    out_next.rst   = (st_next != SRDM_ST_RUN);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_reg <= '{rst_n: 1'b0, rst: 1'b1};
    end else begin
      out_reg <= out_next;
    end
  end
  assign rst_out = out_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_comp;
    @(posedge mclk) disable iff (!reset_n) rst_out.rst_n != rst_out.rst;
  endproperty
  a_comp: assert property (p_comp) else $error("reset outputs not complementary");

  property p_supply_drop;
    @(posedge mclk) disable iff (!reset_n) !sup_ok |=> !rst_out.rst_n && rst_out.rst;
  endproperty
  a_supply_drop: assert property (p_supply_drop) else $error("supply low not asserting reset");

  property p_mr_qual;
    @(posedge mclk) disable iff (!reset_n) mr_qual |=> !rst_out.rst_n;
  endproperty
  a_mr_qual: assert property (p_mr_qual) else $error("manual reset not asserting");

  property p_glitch;
    @(posedge mclk) disable iff (!reset_n) $rose(mr_low) |-> !mr_qual [*8];
  endproperty
  a_glitch: assert property (p_glitch) else $error("short manual pulse qualified");

  property p_wd;
    @(posedge mclk) disable iff (!reset_n) wd_exp |=> rst_out.rst;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog expiry not asserting");

  property p_release_needs_hold;
    @(posedge mclk) disable iff (!reset_n)
      $rose(rst_out.rst_n) |-> $past(st_reg) == SRDM_ST_HOLD && $past(hold_reg) >= hold_len(hold_sel) - 1'b1;
  endproperty
  a_release_needs_hold: assert property (p_release_needs_hold) else $error("release before hold expired");

  // Restart in two steps: a cause seen mid-hold, then a cleared count with reset still driven
  sequence s_cause_in_hold;
    st_reg == SRDM_ST_HOLD && cause;
  endsequence

  sequence s_count_cleared;
    hold_reg == '0 ##1 rst_out.rst;
  endsequence

  property p_restart;
    @(posedge mclk) disable iff (!reset_n) s_cause_in_hold |=> s_count_cleared;
  endproperty
  a_restart: assert property (p_restart) else $error("hold not restarted on cause");

  property p_hold_active;
    @(posedge mclk) disable iff (!reset_n) st_reg == SRDM_ST_HOLD |-> rst_out.rst;
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("reset released during hold");

  // A qualify must follow a low line that outlasted the glitch window
  property p_qual_needs_low;
    @(posedge mclk) disable iff (!reset_n) $rose(mr_qual) |-> $past(mr_low) && $past(mr_low, SRDM_GLITCH_CYC);
  endproperty
  a_qual_needs_low: assert property (p_qual_needs_low) else $error("manual reset qualified too soon");

  // Release only follows a cycle with good supply and no watchdog expiry
  property p_release_needs_supply;
    @(posedge mclk) disable iff (!reset_n) $rose(rst_out.rst_n) |-> $past(sup_ok) && !$past(wd_exp);
  endproperty
  a_release_needs_supply: assert property (p_release_needs_supply) else $error("release with cause present");

endmodule // srdm_supervisor

//--- rtl/srdm_pkg.sv
package srdm_pkg;

  // ==========================================================================
  // Hold delay build options
  // ==========================================================================
  typedef enum logic [1:0] {
    SRDM_HOLD_1P4MS = 2'b00,
    SRDM_HOLD_30MS  = 2'b01,
    SRDM_HOLD_200MS = 2'b10,
    SRDM_HOLD_1P6S  = 2'b11
  } srdm_hold_sel_t;

  // ==========================================================================
  // Timing figures and derived cycle counts at 250 MHz
  // ==========================================================================
  localparam int  SRDM_CLK_MHZ           = 250;
  localparam real SRDM_HOLD_1P4_MS       = 1.4;
  localparam int  SRDM_HOLD_30_MS        = 30;
  localparam int  SRDM_HOLD_200_MS       = 200;
  localparam real SRDM_HOLD_1P6_S        = 1.6;
  localparam int  SRDM_HOLD_MIN_200_MS   = 140;
  localparam int  SRDM_HOLD_MAX_200_MS   = 280;
  localparam int  SRDM_GLITCH_NS         = 100;
  localparam int  SRDM_QUALIFY_US        = 10;
  localparam int  SRDM_GLITCH_CYC        = (SRDM_GLITCH_NS * SRDM_CLK_MHZ + 999) / 1000;
  localparam int  SRDM_HOLD_1P4_CYC      = int'(SRDM_HOLD_1P4_MS * 1000.0) * SRDM_CLK_MHZ;
  localparam int  SRDM_HOLD_30_CYC       = SRDM_HOLD_30_MS * 1000 * SRDM_CLK_MHZ;
  localparam int  SRDM_HOLD_200_CYC      = SRDM_HOLD_200_MS * 1000 * SRDM_CLK_MHZ;
  localparam int  SRDM_HOLD_1P6_CYC      = int'(SRDM_HOLD_1P6_S * 1000000.0) * SRDM_CLK_MHZ;
  localparam int  SRDM_QUALIFY_CYC       = SRDM_QUALIFY_US * SRDM_CLK_MHZ;
  localparam int  SRDM_CNT_W             = 32;
  localparam logic [1:0] SRDM_SEL_RESET  = 2'b10;

  // ==========================================================================
  // Sequencer states and reset output pair
  // ==========================================================================
  typedef enum logic [1:0] {
    SRDM_ST_ASSERT = 2'b00,
    SRDM_ST_HOLD   = 2'b01,
    SRDM_ST_RUN    = 2'b10
  } srdm_state_t;

  typedef struct packed {
    logic rst_n;
    logic rst;
  } srdm_rst_out_t;

endpackage

//--- dv/srdm_host_model.sv
`timescale 1ns/100ps
// ============================================================================
// Host side: push button on the manual reset line, host held while reset
// ============================================================================
module srdm_host_model
  import srdm_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          press,
  input  wire srdm_rst_out_t rst_out,
  output logic               manual_reset_n_input,
  output logic               host_held
);
  // Line sits high through the pull-up and goes low only while pressed
  always_comb manual_reset_n_input = ~press;
  // Host stays in reset while the low-active output is low
  always_ff @(posedge mclk) host_held <= ~rst_out.rst_n;
endmodule // srdm_host_model

//--- dv/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
// ============================================================================
// Bench for the reset delay and manual reset sequencer
// ============================================================================
module tb;
  import srdm_pkg::*;
  localparam int            QC     = 30;
  localparam int            HL [4] = '{50, 60, 100, 200};
  localparam srdm_rst_out_t ACT    = 2'b01;
  localparam srdm_rst_out_t REL    = 2'b10;
  logic           mclk;
  logic           reset_n;
  logic           supply_ok;
  logic           watchdog_expired;
  logic           press;
  logic           mr_n;
  logic           host_held;
  srdm_hold_sel_t hold_sel;
  srdm_rst_out_t  rst_out;
  int             errors;
  int             n_checks;

  srdm_supervisor #(.HOLD_1P4_CYC(HL[0]), .HOLD_30_CYC(HL[1]), .HOLD_200_CYC(HL[2]),
                    .HOLD_1P6_CYC(HL[3]), .QUALIFY_CYC(QC)) u_srdm_supervisor (
    .mclk(mclk), .reset_n(reset_n), .supply_ok(supply_ok), .manual_reset_n_input(mr_n),
    .watchdog_expired(watchdog_expired), .hold_sel(hold_sel), .rst_out(rst_out));
  srdm_host_model u_srdm_host_model (
    .mclk(mclk), .press(press), .rst_out(rst_out), .manual_reset_n_input(mr_n), .host_held(host_held));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Every cycle in the window must show the active pair
  task automatic active_for(int n, string m);
    for (int i = 0; i < n; i++) begin
      cyc(1);
      `CHK(rst_out, ACT, m)
    end
  endtask
  // Release may lag by sync plus output register, never more than 12
  task automatic release_by(int n, string m);
    int i;
    for (i = 0; i < n && rst_out !== REL; i++) cyc(1);
    `CHK(rst_out, REL, m)
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Shipped cycle counts against the typical hold figures at 250 MHz, the 200 ms one against its 140 to 280 ms band
  task automatic t_defaults();
    `CHK(SRDM_HOLD_1P4_CYC, 350000, "1.4 ms count")
    `CHK(SRDM_HOLD_30_CYC, 7500000, "30 ms count")
    `CHK(SRDM_HOLD_200_CYC >= 35000000 && SRDM_HOLD_200_CYC <= 70000000, 1'b1, "200 ms out of band")
    `CHK(SRDM_HOLD_1P6_CYC, 400000000, "1.6 s count")
    `CHK(SRDM_SEL_RESET, SRDM_HOLD_200MS, "default option")
    `CHK(SRDM_GLITCH_CYC, 25, "glitch window")
    $display("test defaults done");
  endtask
  task automatic t_supply(int s);
    @(posedge mclk) supply_ok <= 1'b0;
    @(posedge mclk) hold_sel <= srdm_hold_sel_t'(s);
    cyc(6);
    `CHK(rst_out, ACT, "low supply")
    @(posedge mclk) supply_ok <= 1'b1;
    active_for(HL[s], "early release");
    release_by(12, "late release");
    $display("test supply sel %0d done", s);
  endtask
  task automatic t_glitch();
    @(posedge mclk) press <= 1'b1;
    cyc(20);
    @(posedge mclk) press <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      `CHK(rst_out, REL, "short press")
    end
    $display("test glitch done");
  endtask
  task automatic t_manual();
    @(posedge mclk) press <= 1'b1;
    cyc(QC + 8);
    `CHK(rst_out, ACT, "press not seen")
    `CHK(host_held, 1'b1, "host not held")
    @(posedge mclk) press <= 1'b0;
    active_for(HL[2], "manual hold short");
    release_by(12, "manual no release");
    $display("test manual done");
  endtask
  task automatic t_restart();
    @(posedge mclk) watchdog_expired <= 1'b1;
    cyc(2); // Two sync stages pass before the output register reacts
    active_for(6, "watchdog");
    @(posedge mclk) watchdog_expired <= 1'b0;
    active_for(HL[2] / 2, "first hold");
    @(posedge mclk) watchdog_expired <= 1'b1;
    cyc(3);
    @(posedge mclk) watchdog_expired <= 1'b0;
    active_for(HL[2], "hold not restarted");
    release_by(12, "restart no release");
    $display("test restart done");
  endtask

  // ==========================================================================
  // Verdict
  // ==========================================================================
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Clock at 250 MHz
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Watchdog well past the expected 1000 or so cycles
  initial begin
    #100000;
    errors++;
    results();
  end
  // Main sequence
  initial begin
    errors = 0;
    n_checks = 0;
    reset_n = 1'b0;
    supply_ok = 1'b0;
    watchdog_expired = 1'b0;
    press = 1'b0;
    hold_sel = SRDM_HOLD_200MS;
    cyc(20);
    `CHK(rst_out, ACT, "power-up")
    t_defaults();
    @(posedge mclk) reset_n <= 1'b1;
    for (int s = 0; s < 4; s++) t_supply(s);
    @(posedge mclk) hold_sel <= SRDM_HOLD_200MS;
    t_supply(2);
    t_glitch();
    t_manual();
    t_restart();
    results();
  end
endmodule // tb
